// ### bench/tag_ctrl_props.sv
// Checker for the tag_ctrl memory pin protocol
// Assumes it is bound to the tag_ctrl ports
`timescale 1ns/10ps
module tag_ctrl_props (
    // Clock, reset and user side
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic req_valid_in,
    input wire logic [1:0] req_op_in,
    input wire logic req_ready_out,
    input wire logic resp_valid_out,
    // Memory pins
    input wire logic [tag_ctrl_pkg::ADDR_W-1:0] mem_addr_out,
    input wire logic mem_data_oe_n_out,
    input wire logic mem_cs_n_out,
    input wire logic mem_we_n_out,
    input wire logic mem_oe_n_out,
    input wire logic mem_clear_n_out
);
    import tag_ctrl_pkg::*;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // **********
    // Properties
    // **********
    chk_write_pulse_len: assert property (
        $fell(mem_we_n_out) |-> (!mem_we_n_out && !mem_cs_n_out) [*3]) else $error("write pulse short");
    chk_write_answer: assert property (
        req_valid_in && req_ready_out && req_op_in == OP_WRITE |-> ##8 resp_valid_out) else $error("write late");
    chk_addr_quiet: assert property (
        !$stable(mem_addr_out) |-> mem_we_n_out && mem_cs_n_out) else $error("address moved while active");
    chk_no_bus_fight: assert property (
        !mem_cs_n_out && !mem_oe_n_out |-> mem_data_oe_n_out) else $error("data pins contested");
    chk_read_we_high: assert property (
        !mem_oe_n_out |-> mem_we_n_out) else $error("strobe low in read");
    chk_clear_width: assert property (
        $fell(mem_clear_n_out) |-> !mem_clear_n_out [*6]) else $error("clear pulse short");
    chk_clear_recover: assert property (
        $rose(mem_clear_n_out) |-> mem_we_n_out [*2]) else $error("strobe too soon after clear");
    chk_compare_driven: assert property (
        !mem_cs_n_out && mem_oe_n_out && mem_we_n_out |-> !mem_data_oe_n_out) else $error("data floating");
endmodule // tag_ctrl_props
bind tag_ctrl tag_ctrl_props i_props (.clk_in, .rst_n_in, .req_valid_in, .req_op_in, .req_ready_out,
    .resp_valid_out, .mem_addr_out, .mem_data_oe_n_out, .mem_cs_n_out, .mem_we_n_out, .mem_oe_n_out,
    .mem_clear_n_out);

// ### bench/tag_ctrl_tb.sv
// Self-checking bench for tag_ctrl with a behavioural tag memory
// Assumes the model and checker are compiled first
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module tag_ctrl_tb;
    import tag_ctrl_pkg::*;
    logic clk_in = 0;
    logic rst_n_in = 0;
    logic req_valid_in = 0;
    logic [1:0] req_op_in = 0;
    logic [ADDR_W-1:0] req_addr_in = 0;
    logic [DATA_W-1:0] req_data_in = 0;
    logic req_ready_out, resp_valid_out, resp_hit_out, dev_drive, hit;
    logic mem_data_oe_n_out, mem_cs_n_out, mem_we_n_out, mem_oe_n_out, mem_clear_n_out;
    logic [DATA_W-1:0] read_data_out, mem_data_out, dev_data, bus, d;
    logic [ADDR_W-1:0] mem_addr_out, a;
    logic [DATA_W-1:0] shadow [logic [ADDR_W-1:0]];
    logic [1:0] op;
    int err_total = 0;
    int n_checks = 0;
    int seed = 4733;
    assign bus = !mem_data_oe_n_out ? mem_data_out : dev_drive ? dev_data : 8'hA5 ^ {DATA_W{clk_in}};
    initial begin
        forever #5 clk_in = ~clk_in;
    end
    tag_ctrl i_dut (.clk_in, .rst_n_in, .req_valid_in, .req_op_in, .req_addr_in, .req_data_in,
        .req_ready_out, .resp_valid_out, .resp_hit_out, .read_data_out, .mem_addr_out, .mem_data_out,
        .mem_data_oe_n_out, .mem_data_in(bus), .mem_cs_n_out, .mem_we_n_out, .mem_oe_n_out,
        .mem_clear_n_out, .mem_hit_in(hit));
    tag_mem_model i_mem (.addr_in(mem_addr_out), .data_in(bus), .cs_n_in(mem_cs_n_out),
        .we_n_in(mem_we_n_out), .oe_n_in(mem_oe_n_out), .clear_n_in(mem_clear_n_out),
        .drive_out(dev_drive), .data_out(dev_data), .hit_out(hit));
    // **********
    // Helpers
    // **********
    function automatic logic [DATA_W-1:0] exp_rd(logic [ADDR_W-1:0] x);
        return shadow.exists(x) ? shadow[x] : 8'h00;
    endfunction
    function automatic int exp_lat(logic [1:0] o);
        // Setup, timer load, release and answer add four cycles to the waits; a clear, with its second timer load, adds six
        return o == OP_WRITE ? WRITE_PULSE_CYC + 4 : o == OP_CLEAR ? CLEAR_PULSE_CYC + CLEAR_RECOVER_CYC + 6
            : SETTLE_CYC + 4;
    endfunction
    task automatic tally_and_finish();
        $display("Checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic run(input logic [1:0] o, input logic [ADDR_W-1:0] x, input logic [DATA_W-1:0] v);
        int n;
        logic rdy;
        n = 0;
        req_valid_in <= 1'b1;
        req_op_in <= o;
        req_addr_in <= x;
        req_data_in <= v;
        // Outputs are looked at mid-cycle, clear of the edge that updates them
        do begin
            @(negedge clk_in);
            rdy = req_ready_out;
            @(posedge clk_in);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        req_valid_in <= 1'b0;
        if (rdy !== 1'b1) begin
            err_total++;
            tally_and_finish();
        end
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
            @(negedge clk_in);
        end while (resp_valid_out !== 1'b1 && n < 20);
        if (resp_valid_out !== 1'b1) begin
            err_total++;
            tally_and_finish();
        end
        `CHK(n, exp_lat(o))
        if (o == OP_WRITE)
            shadow[x] = v;
        if (o == OP_CLEAR)
            shadow.delete();
        if (o == OP_READ) begin
            `CHK(read_data_out, exp_rd(x))
            `CHK(resp_hit_out, 1'b1)
        end
        if (o == OP_COMPARE)
            `CHK(resp_hit_out, exp_rd(x) == v)
        @(posedge clk_in);
    endtask
    // **********
    // Sequence
    // **********
    initial begin
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        @(negedge clk_in);
        `CHK({req_ready_out, mem_cs_n_out, mem_we_n_out, mem_oe_n_out, mem_clear_n_out}, 5'h1F)
        @(posedge clk_in);
        run(OP_CLEAR, 13'h0000, 8'h00);
        run(OP_READ, 13'h1FFF, 8'h00);
        run(OP_COMPARE, 13'h0ABC, 8'h00);
        run(OP_WRITE, 13'h1FFF, 8'hFF);
        run(OP_WRITE, 13'h0000, 8'h5A);
        run(OP_READ, 13'h1FFF, 8'h00);
        run(OP_COMPARE, 13'h1FFF, 8'h7F);
        run(OP_COMPARE, 13'h0000, 8'h5A);
        // Random traffic over a small window
        repeat (60) begin
            op = 2'($random(seed));
            a = 13'($random(seed)) & 13'h000F;
            d = ($random(seed) & 1) ? exp_rd(a) : 8'($random(seed));
            if (op != OP_CLEAR || ($random(seed) & 7) == 0)
                run(op, a, d);
        end
        run(OP_CLEAR, 13'h0000, 8'h00);
        run(OP_READ, 13'h0000, 8'h00);
        tally_and_finish();
    end
endmodule // tag_ctrl_tb

// ### bench/tag_mem_model.sv
// Behavioural tag memory with compare output
// Assumes the bench feeds back the resolved data bus
`timescale 1ns/10ps
module tag_mem_model (
    // Device pins
    input wire logic [tag_ctrl_pkg::ADDR_W-1:0] addr_in,
    input wire logic [tag_ctrl_pkg::DATA_W-1:0] data_in,
    input wire logic cs_n_in,
    input wire logic we_n_in,
    input wire logic oe_n_in,
    input wire logic clear_n_in,
    // Device drive
    output logic drive_out,
    output logic [tag_ctrl_pkg::DATA_W-1:0] data_out,
    output logic hit_out
);
    import tag_ctrl_pkg::*;
    logic [DATA_W-1:0] cells [2**ADDR_W];
    always @(negedge clear_n_in) begin
        foreach (cells[i]) cells[i] = 8'h00;
    end
    always @* begin
        if (clear_n_in && !cs_n_in && !we_n_in)
            cells[addr_in] = data_in;
    end
    assign drive_out = !cs_n_in && !oe_n_in && we_n_in;
    assign data_out = cells[addr_in];
    assign hit_out = !clear_n_in || cs_n_in || !we_n_in || !oe_n_in || cells[addr_in] == data_in;
endmodule // tag_mem_model

// ### design/tag_ctrl.sv
// Controller driving an asynchronous 8K x 8 tag memory with compare output
// Assumes memory pins are sampled synchronously; hit line pulled up outside
// Function
// R01 - Write lasts while strobe and select both low, at least pulse width.
// R02 - Strobe and select stay inactive while address changes.
// R03 - Select falling with or after strobe keeps device data pins floating.
// R04 - With output enable low in writes, device drive follows written data.
// R05 - Controller never fights device drive on data pins.
// R06 - Strobe held high throughout every read.
// R07 - Strobe low forces hit line high within 23 ns.
// R08 - Clear low forces hit line high within 23 ns.
// R09 - Deselect releases hit line within 18 ns.
// R10 - Hit follows new address within 30 ns in compare mode.
// R11 - Hit follows new data within 23 ns in compare mode.
// R12 - Hit keeps old result at least 5 ns after address change.
// R13 - Clear low at least 55 ns, then 5 ns before strobe falls.
// R14 - Address and data never left floating while hit is used.
// R15 - Clear zeroes every stored word.
// R16 - Array is 8K words of 8 bits with 8-bit comparator.
// R17 - Hit line is open drain, low on any mismatch.
// R18 - Compare mode: strobe high, select low, output enable high.
// R19 - Read mode: select and output enable low, strobe high.
`timescale 1ns/10ps
module tag_ctrl (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // User request
    input wire logic req_valid_in,
    input wire logic [1:0] req_op_in,
    input wire logic [tag_ctrl_pkg::ADDR_W-1:0] req_addr_in,
    input wire logic [tag_ctrl_pkg::DATA_W-1:0] req_data_in,
    // User answer
    output logic req_ready_out,
    output logic resp_valid_out,
    output logic resp_hit_out,
    output logic [tag_ctrl_pkg::DATA_W-1:0] read_data_out,
    // Memory pins
    output logic [tag_ctrl_pkg::ADDR_W-1:0] mem_addr_out,
    output logic [tag_ctrl_pkg::DATA_W-1:0] mem_data_out,
    output logic mem_data_oe_n_out,
    input wire logic [tag_ctrl_pkg::DATA_W-1:0] mem_data_in,
    output logic mem_cs_n_out,
    output logic mem_we_n_out,
    output logic mem_oe_n_out,
    output logic mem_clear_n_out,
    input wire logic mem_hit_in
);
    import tag_ctrl_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_SETUP,
        ST_WRITE,
        ST_READ,
        ST_COMPARE,
        ST_CLEAR,
        ST_RECOVER,
        ST_END
    } phase_t;

    typedef struct packed {
        phase_t phase;
        logic [1:0] op;
        logic ready;
        logic resp_valid;
        logic resp_hit;
        logic [DATA_W-1:0] rdata;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic data_oe_n;
        logic cs_n;
        logic we_n;
        logic oe_n;
        logic clear_n;
        logic load;
        logic [CNT_W-1:0] count;
    } ctrl_state_t;

    ctrl_state_t state;
    ctrl_state_t next_state;
    logic wait_done;

    function automatic logic [CNT_W-1:0] cyc(input int n);
        cyc = CNT_W'(n);
    endfunction

    tag_wait_timer timer (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .load_in(state.load),
        .count_in(state.count),
        .done_out(wait_done)
    );

    always_comb begin
        next_state = state;
        next_state.load = 1'b0;
        next_state.resp_valid = 1'b0;
        case (state.phase)
            ST_IDLE: begin
                if (req_valid_in && state.ready) begin
                    next_state.ready = 1'b0;
                    next_state.op = req_op_in;
                    // R02 address moves
                    next_state.addr = req_addr_in;
                    next_state.wdata = req_data_in;
                    next_state.cs_n = 1'b1;
                    next_state.we_n = 1'b1;
                    next_state.oe_n = 1'b1;
                    // R14 inputs driven
                    next_state.data_oe_n = (req_op_in == OP_READ);
                    next_state.phase = ST_SETUP;
                end
            end
            ST_SETUP: begin
                next_state.load = 1'b1;
                case (state.op)
                    OP_WRITE: begin
                        // R01 write pulse
                        // R03 select with strobe
                        next_state.cs_n = 1'b0;
                        next_state.we_n = 1'b0;
                        next_state.count = cyc(WRITE_PULSE_CYC);
                        next_state.phase = ST_WRITE;
                    end
                    OP_READ: begin
                        // R06 strobe high
                        // R19 read mode
                        next_state.cs_n = 1'b0;
                        next_state.oe_n = 1'b0;
                        next_state.count = cyc(SETTLE_CYC);
                        next_state.phase = ST_READ;
                    end
                    OP_CLEAR: begin
                        // R13 clear width
                        // R15 array zeroed
                        next_state.clear_n = 1'b0;
                        next_state.count = cyc(CLEAR_PULSE_CYC);
                        next_state.phase = ST_CLEAR;
                    end
                    default: begin
                        // R18 compare mode
                        // R10 address settle
                        next_state.cs_n = 1'b0;
                        next_state.count = cyc(SETTLE_CYC);
                        next_state.phase = ST_COMPARE;
                    end
                endcase
            end
            ST_WRITE: begin
                if (wait_done) begin
                    next_state.we_n = 1'b1;
                    next_state.cs_n = 1'b1;
                    next_state.phase = ST_END;
                end
            end
            ST_READ: begin
                if (wait_done) begin
                    next_state.rdata = mem_data_in;
                    next_state.resp_hit = 1'b1;
                    next_state.oe_n = 1'b1;
                    next_state.cs_n = 1'b1;
                    next_state.phase = ST_END;
                end
            end
            ST_COMPARE: begin
                if (wait_done) begin
                    // R17 open drain hit
                    // R11 data settled
                    next_state.resp_hit = mem_hit_in;
                    next_state.cs_n = 1'b1;
                    next_state.phase = ST_END;
                end
            end
            ST_CLEAR: begin
                if (wait_done) begin
                    next_state.clear_n = 1'b1;
                    next_state.load = 1'b1;
                    next_state.count = cyc(CLEAR_RECOVER_CYC);
                    next_state.phase = ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                // R13 recovery before strobe
                if (wait_done) begin
                    next_state.phase = ST_END;
                end
            end
            ST_END: begin
                // R05 controller drives data pins again after deselect
                next_state.data_oe_n = 1'b0;
                next_state.resp_valid = 1'b1;
                next_state.ready = 1'b1;
                next_state.phase = ST_IDLE;
            end
            default: begin
                next_state.phase = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state <= '0;
            state.phase <= ST_IDLE;
            state.ready <= 1'b1;
            state.cs_n <= 1'b1;
            state.we_n <= 1'b1;
            state.oe_n <= 1'b1;
            state.clear_n <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    assign req_ready_out = state.ready;
    assign resp_valid_out = state.resp_valid;
    assign resp_hit_out = state.resp_hit;
    assign read_data_out = state.rdata;
    assign mem_addr_out = state.addr;
    assign mem_data_out = state.wdata;
    assign mem_data_oe_n_out = state.data_oe_n;
    assign mem_cs_n_out = state.cs_n;
    assign mem_we_n_out = state.we_n;
    assign mem_oe_n_out = state.oe_n;
    assign mem_clear_n_out = state.clear_n;
endmodule // tag_ctrl

// ### design/tag_ctrl_pkg.sv
// Constants for the tag memory controller
// Assumes a 100 MHz clock and the fastest device grade
package tag_ctrl_pkg;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int CLK_PERIOD_NS = 10;
    // Device timing in ns
    localparam int WRITE_PULSE_NS = 25;
    localparam int CLEAR_PULSE_NS = 55;
    localparam int CLEAR_RECOVER_NS = 5;
    localparam int ADDR_HIT_NS = 30;
    localparam int DATA_HIT_NS = 23;
    localparam int WE_HIT_NS = 23;
    localparam int CS_ACCESS_NS = 18;
    localparam int HIT_HOLD_NS = 5;
    // Least times round up, at least one cycle
    localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLEAR_PULSE_CYC = (CLEAR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLEAR_RECOVER_CYC = (CLEAR_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Waits for device output to settle, rounded up as well
    localparam int ADDR_HIT_CYC = (ADDR_HIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DATA_HIT_CYC = (DATA_HIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CS_ACCESS_CYC = (CS_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_CYC = (ADDR_HIT_CYC > WE_HIT_NS / CLK_PERIOD_NS + 1) ? ADDR_HIT_CYC
                                : WE_HIT_NS / CLK_PERIOD_NS + 1;
    localparam int CNT_W = 4;
    localparam logic [1:0] OP_COMPARE = 2'h0;
    localparam logic [1:0] OP_READ = 2'h1;
    localparam logic [1:0] OP_WRITE = 2'h2;
    localparam logic [1:0] OP_CLEAR = 2'h3;
endpackage

// ### design/tag_wait_timer.sv
// Down counter that pulses done after a loaded number of cycles
// Assumes load and count share the controller clock
`timescale 1ns/10ps
module tag_wait_timer (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Control
    input wire logic load_in,
    input wire logic [tag_ctrl_pkg::CNT_W-1:0] count_in,
    // Status
    output logic done_out
);
    import tag_ctrl_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic done;
    } timer_state_t;

    timer_state_t state;
    timer_state_t next_state;

    always_comb begin
        next_state = state;
        next_state.done = 1'b0;
        if (load_in) begin
            next_state.count = count_in;
        end else if (state.count != '0) begin
            next_state.count = state.count - 1'b1;
            if (state.count == 4'h1) begin
                next_state.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign done_out = state.done;
endmodule // tag_wait_timer
